// >>> src/fpcbi_pkg.sv
package fpcbi_pkg;
   // interface register offsets, all word aligned
   localparam logic [5:0]  OFS_RESPONSE   = 6'h00;
   localparam logic [5:0]  OFS_CONTROL    = 6'h04;
   localparam logic [5:0]  OFS_SAVE       = 6'h08;
   localparam logic [5:0]  OFS_RESTORE    = 6'h0C;
   localparam logic [5:0]  OFS_COMMAND    = 6'h10;
   localparam logic [5:0]  OFS_OPERAND    = 6'h14;
   localparam logic [5:0]  OFS_INSN_ADDR  = 6'h18;
   localparam logic [5:0]  OFS_FP_CONTROL = 6'h1C;
   localparam logic [5:0]  OFS_FP_STATUS  = 6'h20;
   // fields
   localparam int          CMD_NEEDS_OP_BIT = 14;
   localparam int          CTL_ABORT_BIT    = 0;
   localparam int          CTL_ROUND_LSB    = 4;
   localparam int          CTL_PREC_LSB     = 6;
   localparam int          CTL_TRAP_EN_LSB  = 8;
   localparam int          FP_REG_COUNT     = 8;
   localparam int          FP_REG_WIDTH     = 80;
   // reset values
   localparam logic [31:0] FP_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] INSN_ADDR_RST  = 32'h0000_0000;
   localparam logic [15:0] COMMAND_RST    = 16'h0000;
   // response codes, values arbitrary
   localparam logic [15:0] RESP_DONE      = 16'h0001;
   localparam logic [15:0] RESP_WAIT      = 16'h0002;
   localparam logic [15:0] RESP_XFER_OP   = 16'h0004;
   localparam logic [15:0] RESP_TRAP      = 16'h0008;
   // save frame words, values arbitrary
   localparam logic [15:0] SAVE_NULL_FRAME = 16'h0000;
   localparam logic [15:0] SAVE_IDLE_FRAME = 16'h1100;
   // extra cycles for clocked reads of save and response
   localparam logic [1:0]  SYNC_RD_EXTRA  = 2'h2;
   typedef enum logic [1:0] {
      FPCBI_W32 = 2'b00,
      FPCBI_W16 = 2'b01,
      FPCBI_W8  = 2'b10
   } fpcbi_width_t;
   typedef enum logic [1:0] {
      FPCBI_IDLE = 2'b00,
      FPCBI_HOLD = 2'b01,
      FPCBI_ACK  = 2'b10
   } fpcbi_bus_st_t;
endpackage

// >>> src/fpcbi_bus_iface_unit.sv
`timescale 1ns/100ps
// Contract
// - access begins only with select, address strobe and data strobe, for reads and writes alike
// - interface registers decoded like memory; host talks only by reads and writes
// - response value encodes service the host must perform, e.g. operand transfer
// - new command while the previous instruction is not yet taken answers wait
// - works on 8, 16 or 32 bit host data bus
// - handshake asynchronous; own clock independent of host clock
// - eight general 80 bit floating point data registers
// - 32 bit control register: trap enables, rounding and precision modes
// - 32 bit status register: condition codes, quotient, exception status
// - 32 bit instruction address register for exception handlers
// - device never touches memory; host moves all operands and results
// - exception trap requested through the response; host does processing
// - save and response reads use clocked timing, other reads asynchronous
// - save in reset state yields a single word of state
module fpcbi_bus_iface_unit
   import fpcbi_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_cs_n,
   input  wire logic         i_addr_strobe_n,
   input  wire logic         i_data_strobe_n,
   input  wire logic         i_rw,
   input  wire logic [5:0]   i_addr,
   input  wire logic [31:0]  i_data,
   input  wire logic [1:0]   i_bus_width,
   output logic      [31:0]  o_data,
   output logic              o_data_oe,
   output logic              o_size_ack_low_n,
   output logic              o_size_ack_high_n,
   output logic              o_size_ack_oe,
   output logic              o_insn_valid,
   output logic      [15:0]  o_insn,
   output logic      [31:0]  o_operand,
   input  wire logic         i_exec_take,
   input  wire logic         i_exc_event,
   input  wire logic [31:0]  i_status,
   output logic      [7:0]   o_trap_enable,
   output logic      [1:0]   o_round_mode,
   output logic      [1:0]   o_prec_mode,
   output logic      [31:0]  o_insn_addr,
   input  wire logic         i_fp_we,
   input  wire logic [2:0]   i_fp_widx,
   input  wire logic [79:0]  i_fp_wdata,
   input  wire logic [2:0]   i_fp_ridx,
   output logic      [79:0]  o_fp_rdata
);
   // host pins come from another clock domain
   logic [43:0]   sync1;
   logic [43:0]   sync2;
   logic          cs;
   logic          as;
   logic          ds;
   logic          rw;
   logic [5:0]    addr;
   logic [1:0]    byte_sel;
   logic [31:0]   wdata;
   logic [1:0]    width;
   logic          start;
   fpcbi_bus_st_t state;
   logic [1:0]    hold_cnt;
   logic          act;
   logic [3:0]    be;
   logic          last_lane;
   logic [31:0]   lane_in;
   logic [15:0]   command;
   logic [31:0]   operand;
   logic [31:0]   fp_control;
   logic [31:0]   insn_addr;
   logic          need_op;
   logic          pend;
   logic          exc_pend;
   logic          reset_state;
   logic [15:0]   response;
   logic [31:0]   rd_val;
   logic [31:0]   cmd_merged;
   logic [FP_REG_WIDTH-1:0] fp_regs [FP_REG_COUNT];

   function automatic logic [3:0] lane_be(input logic [1:0] w, input logic [1:0] a);
      unique case (w)
         FPCBI_W16: lane_be = a[1] ? 4'h3 : 4'hC;
         FPCBI_W8:  lane_be = 4'h8 >> a;
         default:   lane_be = 4'hF;
      endcase
   endfunction

   function automatic logic [31:0] lane_shift(input logic [1:0] w, input logic [1:0] a,
                                              input logic [31:0] v, input logic to_bus);
      logic [4:0] sh;
      sh = 5'h00;
      unique case (w)
         FPCBI_W16: sh = {a[1], 4'h0};
         FPCBI_W8:  sh = {a, 3'h0};
         default:   sh = 5'h00;
      endcase
      lane_shift = to_bus ? (v << sh) : (v >> sh);
   endfunction

   // lanes being written replace old bytes, the rest keep what narrow writes left
   function automatic logic [31:0] lane_merge(input logic [3:0] en, input logic [31:0] v,
                                              input logic [31:0] old);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (en[b]) m[b*8 +: 8] = v[b*8 +: 8];
      end
      lane_merge = m;
   endfunction

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1 <= {3'h7, 41'h0};
         sync2 <= {3'h7, 41'h0};
      end else begin
         sync1 <= {i_cs_n, i_addr_strobe_n, i_data_strobe_n, i_rw, i_addr, i_data, i_bus_width};
         sync2 <= sync1;
      end
   end

   assign cs    = !sync2[43];
   assign as    = !sync2[42];
   assign ds    = !sync2[41];
   assign rw    = sync2[40];
   // decode on the word address; the byte lane only steers data
   assign addr     = {sync2[39:36], 2'h0};
   assign byte_sel = sync2[35:34];
   assign wdata = sync2[33:2];
   assign width = sync2[1:0];
   // writes wait for the data strobe too so data is settled
   assign start = cs && as && (ds || !rw) && (ds || rw);
   assign be        = lane_be(width, byte_sel);
   assign last_lane = be[0];
   assign lane_in   = lane_shift(width, byte_sel, wdata, 1'b0);

   // access handshake
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state    <= FPCBI_IDLE;
         hold_cnt <= 2'h0;
      end else begin
         unique case (state)
            FPCBI_IDLE: if (start) begin
               if (rw && (addr == OFS_SAVE || addr == OFS_RESPONSE)) begin
                  state    <= FPCBI_HOLD;
                  hold_cnt <= SYNC_RD_EXTRA;
               end else begin
                  state <= FPCBI_ACK;
               end
            end
            FPCBI_HOLD: begin
               hold_cnt <= hold_cnt - 2'h1;
               if (hold_cnt == 2'h1) state <= FPCBI_ACK;
            end
            FPCBI_ACK: if (!start) state <= FPCBI_IDLE;
            default: state <= FPCBI_IDLE;
         endcase
      end
   end
   assign act = (state == FPCBI_IDLE) && start;

   assign o_size_ack_low_n  = !(state == FPCBI_ACK);
   assign o_size_ack_high_n = !(state == FPCBI_ACK);
   assign o_size_ack_oe     = (state == FPCBI_ACK);
   assign o_data_oe         = (state == FPCBI_ACK) && rw;

   // response encoding, trap first, then wait, then transfer
   always_comb begin
      if (exc_pend)     response = RESP_TRAP;
      else if (pend)    response = RESP_WAIT;
      else if (need_op) response = RESP_XFER_OP;
      else              response = RESP_DONE;
   end

   always_comb begin
      unique case (addr)
         OFS_RESPONSE:   rd_val = {16'h0000, response};
         OFS_SAVE:       rd_val = {16'h0000, reset_state ? SAVE_NULL_FRAME
                                                        : SAVE_IDLE_FRAME};
         OFS_COMMAND:    rd_val = {16'h0000, command};
         OFS_OPERAND:    rd_val = operand;
         OFS_INSN_ADDR:  rd_val = insn_addr;
         OFS_FP_CONTROL: rd_val = fp_control;
         OFS_FP_STATUS:  rd_val = i_status;
         default:        rd_val = 32'h0000_0000;
      endcase
   end

   // data out latched at access start and held through the ack
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) o_data <= 32'h0000_0000;
      else if (act && rw) o_data <= lane_shift(width, byte_sel, rd_val, 1'b1);
   end

   // register writes, merged per lane for narrow buses
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fp_control <= FP_CONTROL_RST;
         insn_addr  <= INSN_ADDR_RST;
         operand    <= 32'h0000_0000;
         command    <= COMMAND_RST;
      end else if (act && !rw) begin
         for (int b = 0; b < 4; b++) begin
            if (be[b] && addr == OFS_FP_CONTROL)
               fp_control[b*8 +: 8] <= lane_in[b*8 +: 8];
            if (be[b] && addr == OFS_INSN_ADDR)
               insn_addr[b*8 +: 8] <= lane_in[b*8 +: 8];
            if (be[b] && addr == OFS_OPERAND)
               operand[b*8 +: 8] <= lane_in[b*8 +: 8];
         end
         for (int b = 0; b < 2; b++) begin
            if (be[b] && addr == OFS_COMMAND && !pend && !need_op)
               command[b*8 +: 8] <= lane_in[b*8 +: 8];
         end
      end
   end

   assign o_trap_enable = fp_control[CTL_TRAP_EN_LSB +: 8];
   assign o_round_mode  = fp_control[CTL_ROUND_LSB +: 2];
   assign o_prec_mode   = fp_control[CTL_PREC_LSB +: 2];
   assign o_insn_addr   = insn_addr;

   // instruction sequencing toward the execution unit
   logic wr_done;
   logic cmd_done;
   logic op_done;
   logic abort;
   assign wr_done  = act && !rw && last_lane;
   assign cmd_done = wr_done && addr == OFS_COMMAND && !pend && !need_op;
   assign op_done  = wr_done && addr == OFS_OPERAND && need_op;
   assign abort    = wr_done && addr == OFS_CONTROL && lane_in[CTL_ABORT_BIT];
   // on an 8 bit bus the upper command byte arrived in an earlier access
   assign cmd_merged = lane_merge(be, lane_in, {16'h0000, command});

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         need_op      <= 1'b0;
         pend         <= 1'b0;
         o_insn_valid <= 1'b0;
         o_insn       <= COMMAND_RST;
         o_operand    <= 32'h0000_0000;
      end else begin
         o_insn_valid <= 1'b0;
         if (abort) begin
            need_op <= 1'b0;
            pend    <= 1'b0;
         end else if (cmd_done && cmd_merged[CMD_NEEDS_OP_BIT]) begin
            need_op <= 1'b1;
         end else if ((cmd_done && !cmd_merged[CMD_NEEDS_OP_BIT]) || op_done) begin
            need_op      <= 1'b0;
            pend         <= 1'b1;
            o_insn_valid <= 1'b1;
            o_insn       <= cmd_done ? cmd_merged[15:0] : command;
            o_operand    <= op_done ? lane_merge(be, lane_in, operand) : operand;
         end else if (i_exec_take) begin
            pend <= 1'b0;
         end
      end
   end

   // trap request: a new event wins over the clearing read
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) exc_pend <= 1'b0;
      else if (i_exc_event) exc_pend <= 1'b1;
      else if (act && rw && addr == OFS_RESPONSE && exc_pend) exc_pend <= 1'b0;
   end

   // reset state lasts until the first command or a non null restore
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) reset_state <= 1'b1;
      else if (cmd_done) reset_state <= 1'b0;
      else if (wr_done && addr == OFS_RESTORE)
         reset_state <= (lane_in[15:0] == SAVE_NULL_FRAME);
   end

   // data registers, filled and read by the execution side
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int r = 0; r < FP_REG_COUNT; r++) fp_regs[r] <= '0;
         o_fp_rdata <= '0;
      end else begin
         if (i_fp_we) fp_regs[i_fp_widx] <= i_fp_wdata;
         o_fp_rdata <= fp_regs[i_fp_ridx];
      end
   end

   // checks
   sequence clocked_rd_s;
      state == FPCBI_IDLE && start && rw && (addr == OFS_SAVE || addr == OFS_RESPONSE);
   endsequence
   sequence hold_then_ack_s;
      (state == FPCBI_HOLD) [*2] ##1 (state == FPCBI_ACK);
   endsequence

   ack_needs_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(!o_size_ack_low_n) |-> $past(start))
      else $error("ack without access begin");
   ack_pair_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_size_ack_low_n == o_size_ack_high_n)
      else $error("size acks differ");
   ack_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (!o_size_ack_low_n && !start) |=> o_size_ack_low_n)
      else $error("ack held after begin dropped");
   clocked_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      clocked_rd_s |=> hold_then_ack_s)
      else $error("clocked read not delayed");
   async_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (act && !(addr == OFS_SAVE || addr == OFS_RESPONSE)) |=> !o_size_ack_low_n)
      else $error("plain access not acked next cycle");
   busy_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (pend && !exc_pend && act && rw && addr == OFS_RESPONSE)
      |=> o_data == lane_shift($past(width), $past(byte_sel), {16'h0, RESP_WAIT}, 1'b1))
      else $error("busy but no wait response");
   trap_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_exc_event |=> exc_pend && response == RESP_TRAP)
      else $error("trap event lost");
   null_save_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (reset_state && act && rw && addr == OFS_SAVE)
      |=> o_data == lane_shift($past(width), $past(byte_sel), {16'h0, SAVE_NULL_FRAME}, 1'b1))
      else $error("reset state save not single null word");
   xfer_req_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (cmd_done && cmd_merged[CMD_NEEDS_OP_BIT] && !abort) |=> need_op ##0 !o_insn_valid)
      else $error("operand request missing");
   handoff_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_insn_valid |-> pend ##1 (pend || $past(i_exec_take) || $past(abort)))
      else $error("handoff without busy");
endmodule

// >>> testbench/fpcbi_host_model.sv
`timescale 1ns/100ps
module fpcbi_host_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_rdata,
   input  wire logic        i_rdata_oe,
   input  wire logic        i_ack_low_n,
   input  wire logic        i_ack_high_n,
   input  wire logic        i_ack_oe,
   output logic             o_cs_n = 1'b1,
   output logic             o_as_n = 1'b1,
   output logic             o_ds_n = 1'b1,
   output logic             o_rw = 1'b1,
   output logic [5:0]       o_addr = 6'h00,
   output logic [31:0]      o_data = 32'h0
);
   // an undriven ack is no answer
   wire ack = i_ack_oe & ~i_ack_low_n & ~i_ack_high_n;
   task automatic drive(input logic cs, as, ds, rw, input logic [5:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_cs_n <= cs;
      o_as_n <= as;
      o_ds_n <= ds;
      o_rw <= rw;
      o_addr <= a;
      o_data <= d;
   endtask
   // waits on the ack rather than a fixed count, giving up after 40 cycles
   task automatic access(input logic rw, input logic [5:0] a, input logic [31:0] d,
                         output logic [31:0] rd, output int cyc, output logic ok);
      int n;
      drive(1'b0, 1'b0, 1'b0, rw, a, d);
      cyc = 0;
      do begin
         @(posedge i_clk);
         cyc++;
      end while (!ack && cyc < 40);
      ok = ack & (i_rdata_oe === rw);
      rd = i_rdata;
      // released data lines show the inverse, not the old value
      drive(1'b1, 1'b1, 1'b1, rw, a, ~d);
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (ack && n < 10);
      ok = ok & ~ack;
   endtask
   task automatic stray(input logic cs, input logic ds, output logic ok);
      drive(cs, 1'b0, ds, 1'b1, 6'h00, 32'h0);
      ok = 1'b1;
      repeat (8) begin
         @(posedge i_clk);
         if (ack) ok = 1'b0;
      end
      drive(1'b1, 1'b1, 1'b1, 1'b1, 6'h00, 32'hFFFF_FFFF);
      repeat (4) @(posedge i_clk);
   endtask
endmodule

// >>> testbench/fp_coprocessor_bus_interface_tb.sv
`timescale 1ns/100ps
module fp_coprocessor_bus_interface_tb
   import fpcbi_pkg::*;
;
   logic        i_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [1:0]  i_bus_width = FPCBI_W32;
   logic        i_exec_take = 1'b0;
   logic        i_exc_event = 1'b0;
   logic [31:0] i_status = 32'h0;
   logic        i_fp_we = 1'b0;
   logic [2:0]  i_fp_widx = 3'h0;
   logic [2:0]  i_fp_ridx = 3'h0;
   logic [79:0] i_fp_wdata = 80'h0;
   wire         i_cs_n, i_addr_strobe_n, i_data_strobe_n, i_rw, o_data_oe, o_insn_valid;
   wire         o_size_ack_low_n, o_size_ack_high_n, o_size_ack_oe;
   wire  [5:0]  i_addr;
   wire  [31:0] i_data, o_data, o_operand, o_insn_addr;
   wire  [15:0] o_insn;
   wire  [7:0]  o_trap_enable;
   wire  [1:0]  o_round_mode, o_prec_mode;
   wire  [79:0] o_fp_rdata;
   int          fail_count = 0;
   int          n_compared = 0;
   int          n_hand = 0;
   int          last_cyc;
   fpcbi_bus_iface_unit uut (.*);
   fpcbi_host_model host (.i_clk(i_clk), .i_rdata(o_data), .i_rdata_oe(o_data_oe),
      .i_ack_low_n(o_size_ack_low_n), .i_ack_high_n(o_size_ack_high_n),
      .i_ack_oe(o_size_ack_oe), .o_cs_n(i_cs_n), .o_as_n(i_addr_strobe_n),
      .o_ds_n(i_data_strobe_n), .o_rw(i_rw), .o_addr(i_addr), .o_data(i_data));
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_insn_valid === 1'b1) n_hand <= n_hand + 1;
   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic rw, input logic [5:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
      logic [31:0] rd;
      logic        ok;
      host.access(rw, a, d, rd, last_cyc, ok);
      chk("handshake", 1'b1, ok);
      if (rw) chk("read data", exp, rd);
   endtask
   task automatic take();
      @(posedge i_clk);
      i_exec_take <= 1'b1;
      @(posedge i_clk);
      i_exec_take <= 1'b0;
   endtask
   task automatic t_reset();
      int c;
      chk("acks idle", 2'b11, {o_size_ack_low_n, o_size_ack_high_n});
      chk("modes", 12'h0, {o_trap_enable, o_round_mode, o_prec_mode});
      chk("insn addr", INSN_ADDR_RST, o_insn_addr);
      bus(1'b1, OFS_SAVE, 32'h0, {16'h0, SAVE_NULL_FRAME});
      c = last_cyc;
      bus(1'b1, OFS_FP_CONTROL, 32'h0, FP_CONTROL_RST);
      chk("clocked read delay", SYNC_RD_EXTRA, c - last_cyc);
   endtask
   task automatic t_strobe();
      logic ok;
      host.stray(1'b0, 1'b1, ok);
      chk("no data strobe", 1'b1, ok);
      host.stray(1'b1, 1'b0, ok);
      chk("no select", 1'b1, ok);
   endtask
   task automatic t_handoff();
      int n;
      n = n_hand;
      bus(1'b0, OFS_COMMAND, 32'h0000_0023, 32'h0);
      chk("insn", {n + 1, 16'h0023}, {n_hand, o_insn});
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_WAIT});
      bus(1'b0, OFS_COMMAND, 32'h0000_0045, 32'h0);
      chk("refused", n + 1, n_hand);
      take();
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_DONE});
      bus(1'b1, OFS_SAVE, 32'h0, {16'h0, SAVE_IDLE_FRAME});
      bus(1'b0, OFS_COMMAND, 32'h0000_4011, 32'h0);
      chk("held", n + 1, n_hand);
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_XFER_OP});
      bus(1'b0, OFS_OPERAND, 32'h3F80_0001, 32'h0);
      chk("operand", {n + 2, 16'h4011, 32'h3F80_0001}, {n_hand, o_insn, o_operand});
      take();
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_DONE});
   endtask
   task automatic t_trap();
      @(posedge i_clk);
      i_exc_event <= 1'b1;
      @(posedge i_clk);
      i_exc_event <= 1'b0;
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_TRAP});
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_DONE});
   endtask
   task automatic t_abort();
      int n;
      n = n_hand;
      bus(1'b0, OFS_COMMAND, 32'h0000_4022, 32'h0);
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_XFER_OP});
      bus(1'b0, OFS_COMMAND, 32'h0000_0055, 32'h0);
      bus(1'b0, OFS_OPERAND, 32'h0000_1111, 32'h0);
      chk("operand first", {n + 1, 16'h4022, 32'h0000_1111}, {n_hand, o_insn, o_operand});
      take();
      bus(1'b0, OFS_COMMAND, 32'h0000_4033, 32'h0);
      bus(1'b0, OFS_CONTROL, 32'h0000_0001, 32'h0);
      bus(1'b1, OFS_RESPONSE, 32'h0, {16'h0, RESP_DONE});
      chk("aborted", n + 1, n_hand);
   endtask
   task automatic t_regs();
      bus(1'b0, OFS_FP_CONTROL, 32'h0000_A5B0, 32'h0);
      chk("modes", {8'hA5, 2'h3, 2'h2}, {o_trap_enable, o_round_mode, o_prec_mode});
      bus(1'b1, OFS_FP_CONTROL, 32'h0, 32'h0000_A5B0);
      bus(1'b0, OFS_INSN_ADDR, 32'h1234_5678, 32'h0);
      chk("insn addr", 32'h1234_5678, o_insn_addr);
      @(posedge i_clk);
      i_status <= 32'h0F0A_0503;
      bus(1'b1, OFS_FP_STATUS, 32'h0, 32'h0F0A_0503);
      bus(1'b1, 6'h3C, 32'h0, 32'h0);
      bus(1'b0, OFS_RESTORE, 32'h0, 32'h0);
      bus(1'b1, OFS_SAVE, 32'h0, {16'h0, SAVE_NULL_FRAME});
   endtask
   task automatic t_narrow();
      @(posedge i_clk);
      i_bus_width <= FPCBI_W16;
      // high parts first: the lowest lane completes the register
      bus(1'b0, OFS_FP_CONTROL, 32'h0, 32'h0);
      bus(1'b0, OFS_FP_CONTROL + 6'h02, 32'h3C40_0000, 32'h0);
      chk("modes", {8'h3C, 2'h0, 2'h1}, {o_trap_enable, o_round_mode, o_prec_mode});
      @(posedge i_clk);
      i_bus_width <= FPCBI_W8;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, OFS_INSN_ADDR + 6'(i), {8'(32'h89AB_CDEF >> (24 - 8 * i)), 24'h0}, 32'h0);
      end
      chk("insn addr", 32'h89AB_CDEF, o_insn_addr);
      @(posedge i_clk);
      i_bus_width <= FPCBI_W32;
   endtask
   task automatic t_fp_regs();
      for (int i = 0; i < FP_REG_COUNT; i++) begin
         @(posedge i_clk);
         i_fp_we <= 1'b1;
         i_fp_widx <= 3'(i);
         i_fp_wdata <= {16'(i), 64'hA5A5_0000_0000_0000 + 64'(i)};
      end
      @(posedge i_clk);
      i_fp_we <= 1'b0;
      for (int i = 0; i < FP_REG_COUNT; i++) begin
         i_fp_ridx <= 3'(7 - i);
         @(posedge i_clk);
         @(negedge i_clk);
         chk("fp reg", {16'(7 - i), 64'hA5A5_0000_0000_0000 + 64'(7 - i)}, o_fp_rdata);
         @(posedge i_clk);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_clk);
      t_reset();
      t_strobe();
      t_handoff();
      t_trap();
      t_abort();
      t_regs();
      t_narrow();
      t_fp_regs();
      complete_run();
   end
   // the whole sequence needs well under 2000 cycles
   initial begin
      #200000;
      fail_count++;
      complete_run();
   end
endmodule
